// ### ccd_map.svh
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH
// ==========================================================
// Register offsets
`define CCD_OFS_CH2_CTRL      10'h197
`define CCD_OFS_CH2_PWR       10'h198
`define CCD_OFS_CH3_CYCLES    10'h199
`define CCD_OFS_CH3_CTRL      10'h19A
`define CCD_OFS_CH3_PWR       10'h19B
// ==========================================================
// Field positions
`define CCD_LOW_MSB           7
`define CCD_LOW_LSB           4
`define CCD_HIGH_MSB          3
`define CCD_HIGH_LSB          0
`define CCD_BYPASS_BIT        7
`define CCD_IGNSYNC_BIT       6
`define CCD_FORCE_BIT         5
`define CCD_START_BIT         4
`define CCD_PHASE_MSB         3
`define CCD_PHASE_LSB         0
`define CCD_PDOWN_BIT         2
`define CCD_DCCDIS_BIT        0
// ==========================================================
// Reset values and writable masks
`define CCD_RST_CYCLES        8'h00
`define CCD_RST_CTRL          8'h00
`define CCD_RST_PWR           8'h00
`define CCD_PWR_MASK          8'h05
`endif

// ### ccd_pkg.sv
// ==========================================================
// Shared types
package ccd_pkg;
   // Per-channel divider configuration
   typedef struct packed {
      logic [3:0] low_cycles;
      logic [3:0] high_cycles;
      logic       bypass;
      logic       ignore_sync;
      logic       force_high;
      logic       start_high;
      logic [3:0] phase;
      logic       power_down;
      logic       duty_correction_off;
   } ccd_cfg_t;

   // Per-channel output pin group
   typedef struct packed {
      logic [2:0] level;
      logic [2:0] oe_n;
   } ccd_pins_t;
endpackage : ccd_pkg

// ### ccd_divider.sv
`timescale 1ns/1ps
`include "ccd_map.svh"
// ==========================================================
// One channel divider
module ccd_divider
   import ccd_pkg::*;
(
   // Clock and reset
   input  wire logic     clk_in,
   input  wire logic     rst_n_in,
   // Configuration and sync
   input  wire ccd_cfg_t cfg_in,
   input  wire logic     sync_in,
   // Divided output
   output logic          div_out
);
   typedef enum logic [2:0] {
      CCD_HOLD  = 3'b001,
      CCD_DELAY = 3'b010,
      CCD_RUN   = 3'b100
   } ccd_dstate_t;

   ccd_dstate_t state_q, state_d;     // Divider phase
   logic [3:0]  cnt_q, cnt_d;         // Cycle counter
   logic        lvl_q, lvl_d;         // Current level
   logic        sync_act;             // Sync honoured

   assign sync_act = sync_in && !cfg_in.ignore_sync;

   // Next state of the divider
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      lvl_d   = lvl_q;
      unique case (state_q)
         CCD_HOLD: begin
            // Wait for sync release, then apply phase
            lvl_d = cfg_in.start_high;
            cnt_d = cfg_in.phase;
            if (!sync_act) begin
               state_d = (cfg_in.phase == 4'h0) ? CCD_RUN : CCD_DELAY;
               cnt_d   = cfg_in.start_high ? cfg_in.high_cycles : cfg_in.low_cycles;
               if (cfg_in.phase != 4'h0) begin
                  cnt_d = cfg_in.phase - 4'h1;
               end
            end
         end
         CCD_DELAY: begin
            if (cnt_q == 4'h0) begin
               state_d = CCD_RUN;
               cnt_d   = lvl_q ? cfg_in.high_cycles : cfg_in.low_cycles;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         CCD_RUN: begin
            if (cnt_q == 4'h0) begin
               lvl_d = !lvl_q;
               cnt_d = lvl_q ? cfg_in.low_cycles : cfg_in.high_cycles;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: begin
            state_d = CCD_HOLD;
         end
      endcase
      if (sync_act) begin
         state_d = CCD_HOLD;
         lvl_d   = cfg_in.start_high;
      end
   end

   // Divider registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= CCD_HOLD;
         cnt_q   <= 4'h0;
         lvl_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         lvl_q   <= lvl_d;
      end
   end

   assign div_out = lvl_q;
endmodule : ccd_divider

// ### ccd_regs.sv
`timescale 1ns/1ps
`include "ccd_map.svh"
// ==========================================================
// Configuration register file
module ccd_regs
   import ccd_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Register port
   input  wire logic [9:0] addr_in,
   input  wire logic       wr_in,
   input  wire logic [7:0] wdata_in,
   output logic      [7:0] rdata_comb,
   // Configuration
   input  wire logic [7:0] ch2_cycles_in,
   output ccd_cfg_t        ch2_cfg,
   output ccd_cfg_t        ch3_cfg
);
   logic [7:0] ch2_ctrl_q, ch2_ctrl_d;   // Channel 2 control
   logic [7:0] ch2_pwr_q, ch2_pwr_d;     // Channel 2 power
   logic [7:0] ch3_cyc_q, ch3_cyc_d;     // Channel 3 cycles
   logic [7:0] ch3_ctrl_q, ch3_ctrl_d;   // Channel 3 control
   logic [7:0] ch3_pwr_q, ch3_pwr_d;     // Channel 3 power

   // Field unpacking
   function automatic ccd_cfg_t unpack(input logic [7:0] cyc, input logic [7:0] ctl, input logic [7:0] pwr);
      ccd_cfg_t c;
      c.low_cycles          = cyc[`CCD_LOW_MSB:`CCD_LOW_LSB];
      c.high_cycles         = cyc[`CCD_HIGH_MSB:`CCD_HIGH_LSB];
      c.bypass              = ctl[`CCD_BYPASS_BIT];
      c.ignore_sync         = ctl[`CCD_IGNSYNC_BIT];
      c.force_high          = ctl[`CCD_FORCE_BIT];
      c.start_high          = ctl[`CCD_START_BIT];
      c.phase               = ctl[`CCD_PHASE_MSB:`CCD_PHASE_LSB];
      c.power_down          = pwr[`CCD_PDOWN_BIT];
      c.duty_correction_off = pwr[`CCD_DCCDIS_BIT];
      return c;
   endfunction : unpack

   assign ch2_cfg = unpack(ch2_cycles_in, ch2_ctrl_q, ch2_pwr_q);
   assign ch3_cfg = unpack(ch3_cyc_q, ch3_ctrl_q, ch3_pwr_q);

   // Write decode and read mux
   always_comb begin
      ch2_ctrl_d = ch2_ctrl_q;
      ch2_pwr_d  = ch2_pwr_q;
      ch3_cyc_d  = ch3_cyc_q;
      ch3_ctrl_d = ch3_ctrl_q;
      ch3_pwr_d  = ch3_pwr_q;
      rdata_comb = 8'h00;
      unique case (addr_in)
         `CCD_OFS_CH2_CTRL: begin
            rdata_comb = ch2_ctrl_q;
            if (wr_in) ch2_ctrl_d = wdata_in;
         end
         `CCD_OFS_CH2_PWR: begin
            rdata_comb = ch2_pwr_q;
            if (wr_in) ch2_pwr_d = wdata_in & `CCD_PWR_MASK;
         end
         `CCD_OFS_CH3_CYCLES: begin
            rdata_comb = ch3_cyc_q;
            if (wr_in) ch3_cyc_d = wdata_in;
         end
         `CCD_OFS_CH3_CTRL: begin
            rdata_comb = ch3_ctrl_q;
            if (wr_in) ch3_ctrl_d = wdata_in;
         end
         `CCD_OFS_CH3_PWR: begin
            rdata_comb = ch3_pwr_q;
            if (wr_in) ch3_pwr_d = wdata_in & `CCD_PWR_MASK;
         end
         default: begin
            // Unmapped reads zero, writes dropped
            rdata_comb = 8'h00;
         end
      endcase
   end

   // Register storage
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ch2_ctrl_q <= `CCD_RST_CTRL;
         ch2_pwr_q  <= `CCD_RST_PWR;
         ch3_cyc_q  <= `CCD_RST_CYCLES;
         ch3_ctrl_q <= `CCD_RST_CTRL;
         ch3_pwr_q  <= `CCD_RST_PWR;
      end else begin
         ch2_ctrl_q <= ch2_ctrl_d;
         ch2_pwr_q  <= ch2_pwr_d;
         ch3_cyc_q  <= ch3_cyc_d;
         ch3_ctrl_q <= ch3_ctrl_d;
         ch3_pwr_q  <= ch3_pwr_d;
      end
   end
endmodule : ccd_regs

// ### ccd_channel_clock_divider.sv
`timescale 1ns/1ps
`include "ccd_map.svh"
// ==========================================================
// Channel 2 tail and channel 3 clock dividers
// Operation
// - Low time is low field plus one
// - High time is high field plus one
// - Bypass outputs a registered toggle at half the input clock rate
// - Ignore-sync bit decides sync obedience
// - Force level applies only with ignore-sync
// - Force level ignored while bypassed
// - Start level chosen by start bit
// - Four-bit phase offset delays output
// - Power-down tristates all three pairs
// - Duty-correction disable bit turns correction off
module ccd_channel_clock_divider
   import ccd_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       resetn_in,
   // Register port
   input  wire logic [9:0] reg_addr_in,
   input  wire logic       reg_wr_in,
   input  wire logic [7:0] reg_wdata_in,
   output logic      [7:0] reg_rdata_out,
   // Channel 2 cycles field from the adjoining register
   input  wire logic [7:0] ch2_cycles_in,
   // Chip-level sync pin, active high
   input  wire logic       sync_in,
   // Channel 2 output pairs
   output logic      [2:0] channel2_level_out,
   output logic      [2:0] channel2_oe_n_out,
   // Channel 3 output pairs
   output logic      [2:0] channel3_level_out,
   output logic      [2:0] channel3_oe_n_out,
   // Duty correction enables, per channel
   output logic      [1:0] duty_correction_out
);
   // ==========================================================
   // Reset release
   logic [1:0] rst_sync_q;            // Reset shift
   logic       rst_n;                 // Released reset

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ==========================================================
   // Sync pin synchroniser
   logic [2:0] sync_sh_q, sync_sh_d;  // Three-stage shift
   logic       sync_q, sync_d;        // Filtered level

   always_comb begin
      sync_sh_d = {sync_sh_q[1:0], sync_in};
      sync_d    = sync_q;
      // Accept a change once stages two and three agree
      if (sync_sh_q[1] == sync_sh_q[2]) begin
         sync_d = sync_sh_q[2];
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sync_sh_q <= 3'b000;
         sync_q    <= 1'b0;
      end else begin
         sync_sh_q <= sync_sh_d;
         sync_q    <= sync_d;
      end
   end

   // ==========================================================
   // Registers
   ccd_cfg_t   ch2_cfg;               // Channel 2 settings
   ccd_cfg_t   ch3_cfg;               // Channel 3 settings
   logic [7:0] rdata;                 // Read mux

   ccd_regs u_regs (
      .clk_in        (sys_clk_in),
      .rst_n_in      (rst_n),
      .addr_in       (reg_addr_in),
      .wr_in         (reg_wr_in),
      .wdata_in      (reg_wdata_in),
      .rdata_comb    (rdata),
      .ch2_cycles_in (ch2_cycles_in),
      .ch2_cfg       (ch2_cfg),
      .ch3_cfg       (ch3_cfg)
   );

   // ==========================================================
   // Dividers
   logic ch2_div;                     // Channel 2 divided clock
   logic ch3_div;                     // Channel 3 divided clock

   ccd_divider u_div2 (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n),
      .cfg_in   (ch2_cfg),
      .sync_in  (sync_q),
      .div_out  (ch2_div)
   );

   ccd_divider u_div3 (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n),
      .cfg_in   (ch3_cfg),
      .sync_in  (sync_q),
      .div_out  (ch3_div)
   );

   // ==========================================================
   // Output selection
   function automatic logic pick_level(input ccd_cfg_t c, input logic div, input logic clk_lvl);
      logic r;
      r = div;
      if (c.ignore_sync) begin
         r = c.force_high;
      end
      if (c.bypass) begin
         r = clk_lvl;
      end
      return r;
   endfunction : pick_level

   logic       clk_tog_q, clk_tog_d;  // Registered toggle at half the input clock rate
   logic [2:0] ch2_lvl_d, ch3_lvl_d;
   logic [2:0] ch2_oe_d, ch3_oe_d;
   logic [1:0] dcc_d;

   always_comb begin
      clk_tog_d = !clk_tog_q;
      ch2_lvl_d = {3{pick_level(ch2_cfg, ch2_div, clk_tog_q)}};
      ch3_lvl_d = {3{pick_level(ch3_cfg, ch3_div, clk_tog_q)}};
      ch2_oe_d  = ch2_cfg.power_down ? 3'b111 : 3'b000;
      ch3_oe_d  = ch3_cfg.power_down ? 3'b111 : 3'b000;
      if (ch2_cfg.power_down) ch2_lvl_d = 3'b000;
      if (ch3_cfg.power_down) ch3_lvl_d = 3'b000;
      dcc_d = {!ch3_cfg.duty_correction_off, !ch2_cfg.duty_correction_off};
   end

   // Output flops
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         clk_tog_q           <= 1'b0;
         channel2_level_out  <= 3'b000;
         channel3_level_out  <= 3'b000;
         channel2_oe_n_out   <= 3'b000;
         channel3_oe_n_out   <= 3'b000;
         duty_correction_out <= 2'b11;
         reg_rdata_out       <= 8'h00;
      end else begin
         clk_tog_q           <= clk_tog_d;
         channel2_level_out  <= ch2_lvl_d;
         channel3_level_out  <= ch3_lvl_d;
         channel2_oe_n_out   <= ch2_oe_d;
         channel3_oe_n_out   <= ch3_oe_d;
         duty_correction_out <= dcc_d;
         reg_rdata_out       <= rdata;
      end
   end
endmodule : ccd_channel_clock_divider

// ### ccd_props.sv
`timescale 1ns/1ps
`include "ccd_map.svh"
// ==========================================================
// Channel 3 output checks
module ccd_props (
   // Clock, reset and inputs
   input wire logic       sys_clk_in,
   input wire logic       resetn_in,
   input wire logic [9:0] reg_addr_in,
   input wire logic       reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       sync_in,
   // Watched outputs
   input wire logic [2:0] channel3_level_out,
   input wire logic [2:0] channel3_oe_n_out,
   input wire logic [1:0] duty_correction_out
);
   logic [7:0] cyc_q, ctl_q, pwr_q;          // Shadow of channel 3 registers
   logic [5:0] age_q, sage_q, shi_q, run_q;  // Settle, sync and run counters
   logic       lvl_q;                        // Level one cycle back
   wire        lvl = channel3_level_out[0];
   wire        calm = age_q > 6'h2F && sage_q > 6'h2F && ctl_q[7:6] == 2'b00 && !pwr_q[2];
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   // Saturating step
   function automatic logic [5:0] sat(input logic [5:0] v);
      return (v == 6'h3F) ? v : v + 6'h01;
   endfunction : sat
   // Shadow registers and counters
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         {cyc_q, ctl_q, pwr_q, age_q, sage_q, shi_q, run_q, lvl_q} <= '0;
      end else begin
         if (reg_wr_in && reg_addr_in == `CCD_OFS_CH3_CYCLES) cyc_q <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `CCD_OFS_CH3_CTRL) ctl_q <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `CCD_OFS_CH3_PWR) pwr_q <= reg_wdata_in & `CCD_PWR_MASK;
         age_q <= (reg_wr_in && reg_addr_in inside {[`CCD_OFS_CH3_CYCLES:`CCD_OFS_CH3_PWR]}) ? 6'h00 : sat(age_q);
         sage_q <= sync_in ? 6'h00 : sat(sage_q);
         shi_q <= sync_in ? sat(shi_q) : 6'h00;
         run_q <= (lvl != lvl_q) ? 6'h01 : sat(run_q);
         lvl_q <= lvl;
      end
   end
   a_low_run: assert property (calm && lvl && !lvl_q |-> run_q == {2'h0, cyc_q[7:4]} + 6'h01)
      else $error("low run length wrong");
   a_high_run: assert property (calm && !lvl && lvl_q |-> run_q == {2'h0, cyc_q[3:0]} + 6'h01)
      else $error("high run length wrong");
   a_force_level: assert property (age_q > 6'h03 && ctl_q[7:6] == 2'b01 && !pwr_q[2]
      |-> channel3_level_out == {3{ctl_q[5]}})
      else $error("forced level wrong");
   a_bypass_toggle: assert property (age_q > 6'h03 && ctl_q[7] && !pwr_q[2]
      |-> channel3_level_out != $past(channel3_level_out))
      else $error("bypass clock not passing");
   a_pd_tristate: assert property (age_q > 6'h03 && pwr_q[2]
      |-> channel3_oe_n_out == 3'h7 && channel3_level_out == 3'h0)
      else $error("power down not high impedance");
   a_dcc_state: assert property (age_q > 6'h03 |-> duty_correction_out[1] == !pwr_q[0])
      else $error("duty correction state wrong");
   a_sync_hold: assert property (shi_q > 6'h06 && age_q > 6'h03 && ctl_q[7:6] == 2'b00 && !pwr_q[2]
      |-> $stable(channel3_level_out) && channel3_level_out == {3{ctl_q[4]}})
      else $error("sync hold level wrong");
   a_pairs_equal: assert property (channel3_level_out inside {3'h0, 3'h7}
      && channel3_oe_n_out inside {3'h0, 3'h7})
      else $error("output pairs differ");
endmodule : ccd_props

bind ccd_channel_clock_divider ccd_props i_props (.sys_clk_in, .resetn_in, .reg_addr_in, .reg_wr_in,
   .reg_wdata_in, .sync_in, .channel3_level_out, .channel3_oe_n_out, .duty_correction_out);

// ### ccd_rx.sv
`timescale 1ns/1ps
// ==========================================================
// Receiving device: measures run lengths of one output pair
module ccd_rx (
   // Clock and pin
   input  wire logic clk_in,
   input  wire logic level_in,
   input  wire logic oe_n_in,
   // Last complete runs
   output int        high_len_out,
   output int        low_len_out
);
   wire  pin = oe_n_in ? 1'bz : level_in; // Released pair floats
   int   run = 0;                         // Current run length
   logic last = 1'bx;                     // Level one cycle back
   always @(posedge clk_in) begin
      if (pin === last) begin
         run <= run + 1;
      end else begin
         if (last === 1'b1) high_len_out <= run;
         if (last === 1'b0) low_len_out <= run;
         run <= 1;
      end
      last <= pin;
   end
endmodule : ccd_rx

// ### ccd_channel_clock_divider_tb.sv
`timescale 1ns/1ps
`include "ccd_map.svh"
// ==========================================================
// Bench for the channel clock divider
module ccd_channel_clock_divider_tb;
   logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, sync = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00, c2cyc = 8'h00, cyc, rdata;
   logic [2:0] lv2, oe2, lv3, oe3;
   logic [1:0] dcc;
   int         n_errors = 0, compares = 0, hi2, lo2, hi3, lo3, d0, d1, p;
   int         mdl [int];                // Register model
   always #10 clk = ~clk;
   ccd_channel_clock_divider i_dut (.sys_clk_in(clk), .resetn_in(rst_n), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .ch2_cycles_in(c2cyc),
      .sync_in(sync), .channel2_level_out(lv2), .channel2_oe_n_out(oe2), .channel3_level_out(lv3),
      .channel3_oe_n_out(oe3), .duty_correction_out(dcc));
   ccd_rx i_rx2 (.clk_in(clk), .level_in(lv2[0]), .oe_n_in(oe2[0]), .high_len_out(hi2), .low_len_out(lo2));
   ccd_rx i_rx3 (.clk_in(clk), .level_in(lv3[0]), .oe_n_in(oe3[0]), .high_len_out(hi3), .low_len_out(lo3));
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle
   // Register write, one-cycle strobe
   task automatic wreg(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      if (mdl.exists(a)) mdl[a] = (a == `CCD_OFS_CH2_PWR || a == `CCD_OFS_CH3_PWR) ? d & `CCD_PWR_MASK : d;
      @(negedge clk);
      wr = 1'b0;
   endtask : wreg
   // Register read, data one cycle after address
   task automatic rreg(input logic [9:0] a);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      check(rdata, mdl.exists(a) ? 8'(mdl[a]) : 8'h00);
   endtask : rreg
   // Hold sync, then time the restart
   task automatic sync_delay(input logic [7:0] ctl, output int d);
      wreg(`CCD_OFS_CH3_CTRL, ctl);
      sync = 1'b1;
      idle(12);
      check({5'h0, lv3}, ctl[4] ? 8'h07 : 8'h00);
      sync = 1'b0;
      d = 0;
      while (lv3 === {3{ctl[4]}} && d < 100) begin
         @(negedge clk);
         d++;
      end
   endtask : sync_delay
   task automatic results();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   initial begin
      void'($urandom(32'h552b));
      for (int a = 'h197; a <= 'h19B; a++) mdl[a] = 0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      idle(3);
      for (int a = 'h195; a <= 'h19C; a++) rreg(10'(a));
      $display("done: reset values");
      for (int a = 'h195; a <= 'h19C; a++) begin
         wreg(10'(a), 8'($urandom));
         rreg(10'(a));
      end
      for (int a = 'h197; a <= 'h19B; a++) wreg(10'(a), 8'h00);
      $display("done: read back");
      for (int i = 0; i < 4; i++) begin
         cyc = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
         c2cyc = 8'($urandom);
         wreg(`CCD_OFS_CH3_CYCLES, cyc);
         idle(80);
         check(8'(hi3), {4'h0, cyc[3:0]} + 8'h01);
         check(8'(lo3), {4'h0, cyc[7:4]} + 8'h01);
         check(8'(hi2), {4'h0, c2cyc[3:0]} + 8'h01);
         check(8'(lo2), {4'h0, c2cyc[7:4]} + 8'h01);
      end
      $display("done: periods");
      for (int s = 0; s < 2; s++) begin
         p = 1 + $urandom % 15;
         sync_delay(8'(s << 4), d0);
         sync_delay(8'(s << 4) | 8'(p), d1);
         check(8'(d1 - d0), 8'(p));
      end
      $display("done: phase");
      for (int f = 0; f < 2; f++) begin
         sync = f[0];
         wreg(`CCD_OFS_CH3_CTRL, 8'h40 | 8'(f << 5));
         wreg(`CCD_OFS_CH2_CTRL, 8'h40 | 8'(f << 5));
         idle(6);
         check({5'h0, lv3}, f ? 8'h07 : 8'h00);
         check({5'h0, lv2}, f ? 8'h07 : 8'h00);
      end
      sync = 1'b0;
      wreg(`CCD_OFS_CH3_CTRL, 8'hE0);
      idle(8);
      check(8'(hi3), 8'h01);
      check(8'(lo3), 8'h01);
      $display("done: force and bypass");
      wreg(`CCD_OFS_CH3_PWR, 8'hFF);
      wreg(`CCD_OFS_CH2_PWR, 8'h01);
      idle(4);
      check({5'h0, oe3}, 8'h07);
      check({5'h0, oe2}, 8'h00);
      check({5'h0, lv3}, 8'h00);
      check({6'h0, dcc}, 8'h00);
      rreg(`CCD_OFS_CH3_PWR);
      wreg(`CCD_OFS_CH3_PWR, 8'h00);
      idle(4);
      check({5'h0, oe3}, 8'h00);
      check({6'h0, dcc}, 8'h02);
      // Channel 2 power down on its own
      wreg(`CCD_OFS_CH2_PWR, 8'h04);
      idle(4);
      check({5'h0, oe2}, 8'h07);
      check({5'h0, lv2}, 8'h00);
      check({5'h0, oe3}, 8'h00);
      check({6'h0, dcc}, 8'h03);
      $display("done: power down");
      results();
   end
   // Watchdog
   initial begin
      repeat (10000) @(posedge clk);
      n_errors++;
      results();
   end
endmodule : ccd_channel_clock_divider_tb
